// File: scr_cfg.svh
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define SCR_A_IFCFG     15'h0000
`define SCR_A_MODE      15'h0002
`define SCR_A_TYPE      15'h0003
`define SCR_A_PART_LO   15'h0004
`define SCR_A_PART_HI   15'h0005
`define SCR_A_MAKER_LO  15'h000c
`define SCR_A_MAKER_HI  15'h000d
`define SCR_A_STREAM    15'h0010
`define SCR_A_REFCTL    15'h0029
`define SCR_A_POS0      15'h002c
`define SCR_A_POS1      15'h002d
`define SCR_A_POS2      15'h002e

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define SCR_B_SRST      7
`define SCR_B_ASCEND    5
`define SCR_B_RDPIN     4
`define SCR_B_HOLD      0
`define SCR_B_PROC      6
`define SCR_B_RECV      5
`define SCR_B_ZOOM      4
`define SCR_MODE_PD     2'h3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define SCR_RST_IFCFG   8'h30
`define SCR_RST_MODE    8'h00
`define SCR_RST_TYPE    8'h00
`define SCR_RST_STREAM  8'h00
`define SCR_RST_REFCTL  8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing
`define SCR_CLK_PS      8000
`define SCR_SRST_NS     750
`define SCR_SRST_CYC    ((`SCR_SRST_NS * 1000 + `SCR_CLK_PS - 1) / `SCR_CLK_PS)
`define SCR_SCLK_HALF   8
`define SCR_INSTR_BITS  16
`define SCR_XFER_BITS   24

`endif

// File: scr_dev_end.sv
`include "scr_cfg.svh"

module scr_dev_end import scr_pkg::*; #(
    // Identity codes: arbitrary values
    parameter logic [3:0]  TYPE_CODE = 4'ha,
    parameter logic [15:0] PART_ID   = 16'h5a3c,
    parameter logic [15:0] MAKER_ID  = 16'h1e2d
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    scr_link_if.dev          link,
    input  wire logic        sampling_reference_input,
    input  wire logic [23:0] ref_edge_position_status,
    output logic      [1:0]  op_mode,
    output logic             power_down,
    output logic             ref_receiver_enable,
    output logic             ref_processor_enable,
    output logic             ref_window_fine_steps,
    output logic      [3:0]  ref_delay_select,
    output logic             ref_event,
    output logic             soft_reset_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Constants and storage

    localparam scr_dev_st_t RST_ST = '{
        ifcfg   : `SCR_RST_IFCFG,
        mode    : `SCR_RST_MODE,
        type_r  : `SCR_RST_TYPE,
        stream  : `SCR_RST_STREAM,
        refctl  : `SCR_RST_REFCTL,
        default : '0
    };

    localparam logic [6:0] SRST_CYC = 7'(`SCR_SRST_CYC);
    localparam logic [4:0] LAST_INS = 5'(`SCR_INSTR_BITS - 1);
    localparam logic [4:0] DATA0    = 5'(`SCR_INSTR_BITS);
    localparam logic [4:0] LAST_DAT = 5'(`SCR_INSTR_BITS + 7);

    scr_dev_st_t r;
    scr_dev_st_t n;
    logic [3:0]  pins;
    logic        s_sclk;
    logic        s_cs_n;
    logic        s_mosi;
    logic        s_sref;
    logic        rise;
    logic        fall;
    logic [15:0] nin;
    logic [7:0]  byte_v;
    logic [14:0] nxt_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Link pins and reference input cross into clk
    scr_sync2 #(
        .W (4)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({sampling_reference_input, link.mosi, link.cs_n,
                   link.sclk}),
        .q       (pins)
    );

    assign s_sclk = pins[0];
    assign s_cs_n = pins[1];
    assign s_mosi = pins[2];
    assign s_sref = pins[3];

    ////////////////////////////////////////////////////////////////////////////
    // Register read view

    // Byte returned for one address
    function automatic logic [7:0] rd_byte(input scr_dev_st_t st,
                                           input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `SCR_A_IFCFG: begin
                v = {1'b0, st.ifcfg[6:5], 1'b1, st.ifcfg[3:0]};
            end
            `SCR_A_MODE: begin
                v = st.mode;
            end
            `SCR_A_TYPE: begin
                v = {st.type_r[7:4], TYPE_CODE};
            end
            `SCR_A_PART_LO: begin
                v = PART_ID[7:0];
            end
            `SCR_A_PART_HI: begin
                v = PART_ID[15:8];
            end
            `SCR_A_MAKER_LO: begin
                v = MAKER_ID[7:0];
            end
            `SCR_A_MAKER_HI: begin
                v = MAKER_ID[15:8];
            end
            `SCR_A_STREAM: begin
                v = st.stream;
            end
            `SCR_A_REFCTL: begin
                v = st.refctl;
            end
            `SCR_A_POS0: begin
                v = ref_edge_position_status[7:0];
            end
            `SCR_A_POS1: begin
                v = ref_edge_position_status[15:8];
            end
            `SCR_A_POS2: begin
                v = ref_edge_position_status[23:16];
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    assign rise = s_sclk & ~r.sclk_q;
    assign fall = ~s_sclk & r.sclk_q;

    // Frame decode, streaming and register writes
    always_comb begin
        n        = r;
        nin      = {r.instr[14:0], s_mosi};
        byte_v   = {r.rx[6:0], s_mosi};
        nxt_addr = r.addr;
        n.sclk_q = s_sclk;
        n.sref_q = s_sref;
        // Reference edges pass only with both enables set
        n.evt    = s_sref & ~r.sref_q & r.refctl[`SCR_B_RECV]
                   & r.refctl[`SCR_B_PROC];
        if (r.srst != 7'h00) begin
            n.srst = r.srst - 7'h01;
            n.cnt  = 5'h00;
            n.miso = 1'b0;
        end else if (s_cs_n) begin
            n.cnt  = 5'h00;
            n.miso = 1'b0;
        end else if (rise) begin
            if (r.cnt < LAST_INS) begin
                n.instr = nin;
                n.cnt   = r.cnt + 5'h01;
            end else if (r.cnt == LAST_INS) begin
                n.instr = nin;
                n.rd    = nin[15];
                n.addr  = nin[14:0];
                n.tx    = rd_byte(r, nin[14:0]);
                n.cnt   = DATA0;
            end else begin
                n.rx = byte_v;
                if (r.cnt == LAST_DAT) begin
                    // Address step for the next streamed byte
                    if (r.stream[`SCR_B_HOLD]) begin
                        nxt_addr = r.addr;
                    end else if (r.ifcfg[`SCR_B_ASCEND]) begin
                        nxt_addr = r.addr + 15'h0001;
                    end else begin
                        nxt_addr = r.addr - 15'h0001;
                    end
                    n.addr = nxt_addr;
                    n.tx   = rd_byte(r, nxt_addr);
                    n.cnt  = DATA0;
                    if (!r.rd) begin
                        unique case (r.addr)
                            `SCR_A_IFCFG: begin
                                if (byte_v[`SCR_B_SRST]) begin
                                    n.srst = SRST_CYC;
                                end else begin
                                    n.ifcfg = byte_v;
                                end
                            end
                            `SCR_A_MODE: begin
                                n.mode = byte_v;
                            end
                            `SCR_A_TYPE: begin
                                n.type_r = {byte_v[7:4], 4'h0};
                            end
                            `SCR_A_STREAM: begin
                                n.stream = byte_v;
                            end
                            `SCR_A_REFCTL: begin
                                n.refctl = byte_v;
                            end
                            default: begin
                                n.rx = byte_v;
                            end
                        endcase
                    end
                end else begin
                    n.cnt = r.cnt + 5'h01;
                end
            end
        end else if (fall && r.rd && r.cnt >= DATA0) begin
            // Read data leaves on the dedicated output pin
            n.miso = r.tx[7];
            n.tx   = {r.tx[6:0], 1'b0};
        end
        // Registers held at reset values while soft reset runs
        if (n.srst != 7'h00) begin
            n.ifcfg  = `SCR_RST_IFCFG;
            n.mode   = `SCR_RST_MODE;
            n.type_r = `SCR_RST_TYPE;
            n.stream = `SCR_RST_STREAM;
            n.refctl = `SCR_RST_REFCTL;
            n.rd     = 1'b0;
            n.evt    = 1'b0;
        end
        n.pd   = (n.mode[1:0] == `SCR_MODE_PD);
        n.busy = (n.srst != 7'h00);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= RST_ST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // All taken from state flops
    assign link.miso             = r.miso;
    assign op_mode               = r.mode[1:0];
    assign power_down            = r.pd;
    assign ref_receiver_enable   = r.refctl[`SCR_B_RECV];
    assign ref_processor_enable  = r.refctl[`SCR_B_PROC];
    assign ref_window_fine_steps = r.refctl[`SCR_B_ZOOM];
    assign ref_delay_select      = r.refctl[3:0];
    assign ref_event             = r.evt;
    assign soft_reset_busy       = r.busy;

endmodule

// File: scr_host_end.sv
`include "scr_cfg.svh"

module scr_host_end import scr_pkg::*; (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    scr_link_if.host         link,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [14:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    input  wire logic        auto_ref_cal,
    input  wire logic        fast_clock_mode,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic      [7:0]  rsp_rdata
);

    localparam logic [3:0] DIV_LAST = 4'(`SCR_SCLK_HALF - 1);
    localparam logic [4:0] XFER     = 5'(`SCR_XFER_BITS);
    localparam logic [6:0] SRST_CYC = 7'(`SCR_SRST_CYC);

    scr_host_st_t r;
    scr_host_st_t n;
    logic         s_miso;
    logic [7:0]   d;

    // Read pin from the device is resynchronised
    scr_sync2 #(
        .W (1)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (link.miso),
        .q       (s_miso)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Command shaping, frame shifting and reset wait
    always_comb begin
        n       = r;
        n.rsp_v = 1'b0;
        d       = cmd_wdata;
        unique case (r.st)
            SCR_H_IDLE: begin
                if (cmd_valid && r.ready) begin
                    if (cmd_write && cmd_addr == `SCR_A_REFCTL) begin
                        if (auto_ref_cal) begin
                            d[3:0] = 4'h0;
                        end
                        if (fast_clock_mode) begin
                            d[`SCR_B_ZOOM] = 1'b1;
                        end
                    end
                    n.pass2 = 1'b0;
                    n.data2 = d;
                    if (cmd_write && cmd_addr == `SCR_A_REFCTL
                        && d[`SCR_B_PROC] && !r.recv_seen) begin
                        // Receiver first, processor in a second frame; processor dropped if receiver bit clear
                        n.pass2          = d[`SCR_B_RECV];
                        d[`SCR_B_PROC] = 1'b0;
                    end
                    if (cmd_write && cmd_addr == `SCR_A_REFCTL) begin
                        n.recv_seen = n.data2[`SCR_B_RECV];
                    end
                    n.srst_pend = cmd_write && cmd_addr == `SCR_A_IFCFG
                                  && d[`SCR_B_SRST];
                    n.wr    = cmd_write;
                    n.addr  = cmd_addr;
                    n.sh    = {~cmd_write, cmd_addr, d};
                    n.mosi  = ~cmd_write;
                    n.cs_n  = 1'b0;
                    n.bcnt  = 5'h00;
                    n.div   = 4'h0;
                    n.ready = 1'b0;
                    n.st    = SCR_H_SHIFT;
                end
            end
            SCR_H_SHIFT: begin
                n.div = r.div + 4'h1;
                if (r.div == DIV_LAST) begin
                    n.div = 4'h0;
                    if (!r.sclk) begin
                        n.sclk = 1'b1;
                        n.rx   = {r.rx[6:0], s_miso};
                        n.bcnt = r.bcnt + 5'h01;
                    end else begin
                        n.sclk = 1'b0;
                        if (r.bcnt == XFER) begin
                            n.cs_n = 1'b1;
                            n.mosi = 1'b0;
                            n.st   = SCR_H_GAP;
                        end else begin
                            n.sh   = {r.sh[22:0], 1'b0};
                            n.mosi = r.sh[22];
                        end
                    end
                end
            end
            SCR_H_GAP: begin
                n.div = r.div + 4'h1;
                if (r.div == DIV_LAST) begin
                    n.div = 4'h0;
                    if (r.pass2) begin
                        n.pass2 = 1'b0;
                        n.sh    = {1'b0, r.addr, r.data2};
                        n.mosi  = 1'b0;
                        n.cs_n  = 1'b0;
                        n.bcnt  = 5'h00;
                        n.st    = SCR_H_SHIFT;
                    end else if (r.srst_pend) begin
                        n.wcnt = SRST_CYC;
                        n.st   = SCR_H_WAIT;
                    end else begin
                        n.rsp_v = 1'b1;
                        n.rsp_d = r.wr ? 8'h00 : r.rx;
                        n.ready = 1'b1;
                        n.st    = SCR_H_IDLE;
                    end
                end
            end
            SCR_H_WAIT: begin
                // No frames until the device reset is over
                n.wcnt = r.wcnt - 7'h01;
                if (r.wcnt == 7'h01) begin
                    n.srst_pend = 1'b0;
                    n.recv_seen = 1'b0;
                    n.rsp_v     = 1'b1;
                    n.rsp_d     = 8'h00;
                    n.ready     = 1'b1;
                    n.st        = SCR_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '{st: SCR_H_IDLE, cs_n: 1'b1, ready: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    // Pins and user side from flops
    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.mosi = r.mosi;
    assign cmd_ready = r.ready;
    assign rsp_valid = r.rsp_v;
    assign rsp_rdata = r.rsp_d;

endmodule

// File: scr_link_chk.sv
`include "scr_cfg.svh"

module scr_link_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic        sclk_q_r;
    logic [23:0] sh_r;
    logic [4:0]  cnt_r;
    logic [6:0]  quiet_r;
    logic        srst_r;
    logic        recv_r;
    logic        fend;
    logic        to29;

    // Frame end and target decode
    assign fend = cs_n && (cnt_r != 5'h00);
    assign to29 = sh_r[23:8] == 16'h0029;

    // Shadow of the wire: bits, idle time, host history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_q_r <= 1'b0;
            sh_r     <= 24'h000000;
            cnt_r    <= 5'h00;
            quiet_r  <= 7'h00;
            srst_r   <= 1'b0;
            recv_r   <= 1'b0;
        end else begin
            sclk_q_r <= sclk;
            if (cs_n) begin
                cnt_r <= 5'h00;
            end else if (sclk && !sclk_q_r) begin
                cnt_r <= cnt_r + 5'h01;
                sh_r  <= {sh_r[22:0], mosi};
            end
            if (!cs_n) begin
                quiet_r <= 7'h00;
            end else if (quiet_r != 7'h7f) begin
                quiet_r <= quiet_r + 7'h01;
            end
            if (fend) begin
                srst_r <= (sh_r[23:8] == 16'h0000) && sh_r[7];
            end
            if (fend && srst_r == 1'b0 && sh_r[23:7] == 17'h00001) begin
                recv_r <= 1'b0;
            end else if (fend && to29 && sh_r[5]) begin
                recv_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_idle_clock: assert property (cs_n |-> !sclk)
        else $error("serial clock moves outside a frame");
    chk_half_period: assert property (
        $rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("serial clock high phase not 8 cycles");
    chk_mosi_steady: assert property (
        !cs_n && sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data changed while clock high");
    chk_miso_idle: assert property (cs_n[*8] |-> !miso)
        else $error("read pin not low between frames");
    chk_frame_bits: assert property (fend |-> cnt_r == 5'h18)
        else $error("frame bit count not 24");
    chk_gap_min: assert property ($rose(cs_n) |-> cs_n[*8])
        else $error("gap between frames under 8 cycles");
    chk_srst_quiet: assert property (
        $fell(cs_n) && srst_r |-> quiet_r >= 7'(`SCR_SRST_CYC))
        else $error("frame started during soft reset");
    chk_recv_first: assert property (
        fend && to29 && sh_r[6] |-> recv_r)
        else $error("processor enabled before receiver");
endmodule

// File: scr_link_if.sv
interface scr_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    // Device end listens, drives only the read pin
    modport dev  (input sclk, input cs_n, input mosi, output miso);
    // Host end makes the clock and frame
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// File: scr_pkg.sv
package scr_pkg;

    // Host link sequencer states
    typedef enum logic [1:0] {
        SCR_H_IDLE  = 2'b00,
        SCR_H_SHIFT = 2'b01,
        SCR_H_GAP   = 2'b11,
        SCR_H_WAIT  = 2'b10
    } scr_hst_t;

    // Device end state
    typedef struct packed {
        logic        sclk_q;
        logic        sref_q;
        logic [4:0]  cnt;
        logic [15:0] instr;
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  rx;
        logic [7:0]  tx;
        logic        miso;
        logic [6:0]  srst;
        logic [7:0]  ifcfg;
        logic [7:0]  mode;
        logic [7:0]  type_r;
        logic [7:0]  stream;
        logic [7:0]  refctl;
        logic        pd;
        logic        evt;
        logic        busy;
    } scr_dev_st_t;

    // Host end state
    typedef struct packed {
        scr_hst_t    st;
        logic [3:0]  div;
        logic        sclk;
        logic        cs_n;
        logic        mosi;
        logic [23:0] sh;
        logic [7:0]  rx;
        logic [4:0]  bcnt;
        logic        wr;
        logic [14:0] addr;
        logic [7:0]  data2;
        logic        pass2;
        logic        recv_seen;
        logic        srst_pend;
        logic [6:0]  wcnt;
        logic        ready;
        logic        rsp_v;
        logic [7:0]  rsp_d;
    } scr_host_st_t;

endpackage

// File: scr_sync2.sv
module scr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } scr_sync_st_t;

    scr_sync_st_t r;
    scr_sync_st_t n;

    // Second stage only reads the first
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;

endmodule

// File: tb_spi_config_sampling_reference_input_ctrl_regs.sv
`include "scr_cfg.svh"

module tb_spi_config_sampling_reference_input_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        sys_rst;
    logic        cmd_valid;
    logic        cmd_write;
    logic [14:0] cmd_addr;
    logic [7:0]  cmd_wdata;
    logic        auto_ref_cal;
    logic        fast_clock_mode;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_rdata;
    logic        sref;
    logic [1:0]  op_mode;
    logic        power_down;
    logic        recv_en;
    logic        proc_en;
    logic        fine;
    logic [3:0]  dsel;
    logic        ref_event;
    logic        soft_reset_busy;
    logic [7:0]  busy_cnt;
    logic [7:0]  ctl_v;
    int          ev_cnt;
    int          bad_count;
    int          cmp_count;

    // Rows: write, address, write data, expected reply
    logic [31:0] rows [20] = '{
        {1'b0, 15'h0000, 8'h00, 8'h30}, {1'b0, 15'h0003, 8'h00, 8'h0a},
        {1'b0, 15'h0004, 8'h00, 8'h3c}, {1'b0, 15'h0005, 8'h00, 8'h5a},
        {1'b0, 15'h000c, 8'h00, 8'h2d}, {1'b0, 15'h000d, 8'h00, 8'h1e},
        {1'b0, 15'h0010, 8'h00, 8'h00}, {1'b0, 15'h0029, 8'h00, 8'h00},
        {1'b0, 15'h002c, 8'h00, 8'h37}, {1'b0, 15'h002e, 8'h00, 8'h9c},
        {1'b0, 15'h0007, 8'h00, 8'h00}, {1'b1, 15'h0003, 8'hff, 8'h00},
        {1'b0, 15'h0003, 8'h00, 8'hfa}, {1'b1, 15'h0004, 8'h00, 8'h00},
        {1'b0, 15'h0004, 8'h00, 8'h3c}, {1'b1, 15'h000d, 8'h00, 8'h00},
        {1'b0, 15'h000d, 8'h00, 8'h1e}, {1'b1, 15'h0000, 8'h4f, 8'h00},
        {1'b0, 15'h0000, 8'h00, 8'h5f}, {1'b1, 15'h0000, 8'h30, 8'h00}};

    scr_link_if link_if ();

    scr_host_end u_scr_host_end (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .link            (link_if.host),
        .cmd_valid       (cmd_valid),
        .cmd_write       (cmd_write),
        .cmd_addr        (cmd_addr),
        .cmd_wdata       (cmd_wdata),
        .auto_ref_cal    (auto_ref_cal),
        .fast_clock_mode (fast_clock_mode),
        .cmd_ready       (cmd_ready),
        .rsp_valid       (rsp_valid),
        .rsp_rdata       (rsp_rdata)
    );

    // Identity codes: arbitrary values
    scr_dev_end #(.TYPE_CODE(4'ha), .PART_ID(16'h5a3c), .MAKER_ID(16'h1e2d))
    u_scr_dev_end (
        .clk                      (clk),
        .sys_rst                  (sys_rst),
        .link                     (link_if.dev),
        .sampling_reference_input (sref),
        .ref_edge_position_status (24'h9c5a37),
        .op_mode                  (op_mode),
        .power_down               (power_down),
        .ref_receiver_enable      (recv_en),
        .ref_processor_enable     (proc_en),
        .ref_window_fine_steps    (fine),
        .ref_delay_select         (dsel),
        .ref_event                (ref_event),
        .soft_reset_busy          (soft_reset_busy)
    );

    scr_link_chk u_scr_link_chk (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sclk    (link_if.sclk),
        .cs_n    (link_if.cs_n),
        .mosi    (link_if.mosi),
        .miso    (link_if.miso)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and event counters
    // Reference control outputs packed as the register byte
    assign ctl_v = {1'b0, proc_en, recv_en, fine, dsel};
    initial clk = 1'b0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (soft_reset_busy === 1'b1)
            busy_cnt++;
        if (ref_event === 1'b1)
            ev_cnt++;
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One command through the host end, bounded wait for the reply
    task automatic cmd(input logic w, input logic [14:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr  = a;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        chk("cmd_ready", 8'h00, {7'h00, cmd_ready});
        n = 0;
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            bad_count++;
            final_report();
        end
        q = rsp_rdata;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        cmd(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] q;
        cmd(1'b0, a, 8'h00, q);
        chk("rdata", e, q);
    endtask

    // One rising reference edge, expected event count
    task automatic ref_edge(input logic [7:0] e);
        int n0;
        n0 = ev_cnt;
        @(negedge clk);
        sref = 1'b1;
        repeat (12) @(negedge clk);
        sref = 1'b0;
        repeat (6) @(negedge clk);
        chk("ref_event", e, 8'(ev_cnt - n0));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        // About three times the expected run length
        #400000;
        bad_count++;
        final_report();
    end

    // Main sequence
    initial begin
        logic [7:0] q;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 15'h0000;
        cmd_wdata = 8'h00;
        auto_ref_cal = 1'b0;
        fast_clock_mode = 1'b0;
        sref = 1'b0;
        busy_cnt = 8'h00;
        ev_cnt = 0;
        bad_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("idle_wire", 8'h02, {6'h00, link_if.cs_n, link_if.sclk});
        chk("op_mode", 8'h00, {6'h00, op_mode});
        for (int i = 0; i < 20; i++) begin
            cmd(rows[i][31], rows[i][30:16], rows[i][15:8], q);
            chk("row_reply", rows[i][7:0], q);
        end
        ref_edge(8'h00);
        fast_clock_mode = 1'b1;
        wr(15'h0029, 8'h67);
        chk("ref_ctl", 8'h77, ctl_v);
        rd(15'h0029, 8'h77);
        ref_edge(8'h01);
        auto_ref_cal = 1'b1;
        wr(15'h0029, 8'h25);
        rd(15'h0029, 8'h30);
        ref_edge(8'h00);
        wr(15'h0002, 8'h03);
        chk("power_down", 8'h07, {5'h00, power_down, op_mode});
        wr(15'h0010, 8'h01);
        rd(15'h0010, 8'h01);
        wr(15'h0000, 8'h0f);
        rd(15'h0000, 8'h1f);
        busy_cnt = 8'h00;
        wr(15'h0000, 8'h80);
        chk("busy_cycles", 8'(`SCR_SRST_CYC), busy_cnt);
        rd(15'h0000, 8'h30);
        rd(15'h0002, 8'h00);
        rd(15'h0010, 8'h00);
        chk("after_srst", 8'h00, {5'h00, power_down, recv_en, fine});
        auto_ref_cal = 1'b0;
        fast_clock_mode = 1'b0;
        wr(15'h0029, 8'h40);
        rd(15'h0029, 8'h00);
        chk("proc_en", 8'h00, {7'h00, proc_en});
        // Power-up reset in mid-run restores defaults
        wr(15'h0002, 8'h03);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("hard_reset", 8'h00, {5'h00, power_down, op_mode});
        rd(15'h0002, 8'h00);
        final_report();
    end
endmodule
